// >>> irq_cfg.svh
// Constants of the radio core interrupt status and acknowledge block.
// Assumes a 32-bit software port with byte offsets as printed.
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

// ==========================================================================
// Register offsets
`define IRQ_ADDR_W 32
`define IRQ_OFS_ENABLE 32'h4000000c
`define IRQ_OFS_MASKED 32'h40000010
`define IRQ_OFS_RAW 32'h40000014
`define IRQ_OFS_ACK 32'h40000018
`define IRQ_OFS_CONFIG 32'h40000008

// ==========================================================================
// Field layout and reset values
`define IRQ_NSRC 9
`define IRQ_BIT_TICK 0
`define IRQ_BIT_RX 1
`define IRQ_BIT_SLEEP 2
`define IRQ_BIT_EVENT 3
`define IRQ_BIT_CIPHER 4
`define IRQ_BIT_ERROR 5
`define IRQ_BIT_GROSS 6
`define IRQ_BIT_FINE 7
`define IRQ_BIT_RADIO 8
`define IRQ_ENABLE_RST 9'h01f
`define IRQ_FLAGS_RST 9'h000
`define IRQ_CONFIG_LEVEL_BIT 4
`define IRQ_LEVEL_STYLE_RST 1'h1

`endif

// >>> irq_flag_bank.sv
// Sticky pending flags: set by source pulses, cleared by write-one masks.
// Assumes set and clear vectors are synchronous to sys_clk.
`timescale 1ns/1ps
`include "irq_cfg.svh"

module irq_flag_bank #(
  parameter int NSRC = `IRQ_NSRC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [NSRC-1:0] set_pulse,
  input wire logic [NSRC-1:0] clear_mask,
  output logic [NSRC-1:0] flags
);

  // ========================================================================
  // State
  typedef struct packed {
    logic [NSRC-1:0] flags;
  } bank_state_t;

  bank_state_t s_q;
  bank_state_t s_d;

  initial begin
    if (NSRC < 1) begin
      $error("irq_flag_bank needs at least one source.");
    end
  end

  // A set in the same cycle as its clear wins, so no event is lost.
  always_comb begin
    s_d = s_q;
    s_d.flags = (s_q.flags & ~clear_mask) | set_pulse;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_q.flags <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flags = s_q.flags;

endmodule : irq_flag_bank

// >>> irq_pkg.sv
// Types of the radio core interrupt block.
// Assumes irq_cfg.svh is on the include path.
`include "irq_cfg.svh"

package irq_pkg;

  // ========================================================================
  // Carriers
  typedef logic [`IRQ_NSRC-1:0] src_vec_t;

  typedef struct packed {
    logic [`IRQ_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

endpackage : irq_pkg

// >>> irq_read_mux.sv
// Read data selection of the interrupt block register map.
// Assumes the caller registers the result for the one-cycle read latency.
`timescale 1ns/1ps
`include "irq_cfg.svh"

module irq_read_mux (
  input wire logic [`IRQ_ADDR_W-1:0] addr,
  input wire logic [`IRQ_NSRC-1:0] enable,
  input wire logic [`IRQ_NSRC-1:0] raw,
  input wire logic level_style,
  output logic [31:0] rdata
);

  // Reserved bits, the acknowledge register and unmapped offsets read 0.
  always_comb begin
    rdata = 32'h00000000;
    case (addr)
      `IRQ_OFS_ENABLE: begin
        rdata[`IRQ_NSRC-1:0] = enable;
      end
      `IRQ_OFS_MASKED: begin
        rdata[`IRQ_NSRC-1:0] = raw & enable;
      end
      `IRQ_OFS_RAW: begin
        rdata[`IRQ_NSRC-1:0] = raw;
      end
      `IRQ_OFS_CONFIG: begin
        rdata[`IRQ_CONFIG_LEVEL_BIT] = level_style;
      end
      default: begin
        rdata = 32'h00000000;
      end
    endcase
  end

endmodule : irq_read_mux

// >>> radio_core_irq_status_ack.sv
// Interrupt status, masking and acknowledge logic of a radio link core.
// Assumes event inputs are one-cycle pulses synchronous to sys_clk.
//
// What this block does
// - Enable bit 0 gates the base-time tick interrupt; resets to 1.
// - Raw status shows unmasked pending flags, sources at bits 8..0.
// - Masked status shows pending flags only where enabled.
// - Status views are read-only and read 0 after reset.
// - End-of-event flag at bit 3 sets when an event completes.
// - Acknowledge bit 5 clears the error flag.
// - Acknowledge bit 1 clears the reception flag.
// - Acknowledge bit 0 clears the base-time tick flag.
// - Acknowledge bit 4 clears the cipher flag.
// - Acknowledge bit 2 clears the end-of-sleep flag.
// - Acknowledge bits 8, 7, 6 clear radio, fine and gross timer flags.
// - Acknowledge register is write-only and reads 0.
// - Enable bits 8..1 gate the other eight sources.
// - Interrupt output is level, held until acknowledged; style bit is 1.
`timescale 1ns/1ps
`include "irq_cfg.svh"

module radio_core_irq_status_ack #(
  parameter int NSRC = `IRQ_NSRC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [`IRQ_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic tick_event,
  input wire logic receive_event,
  input wire logic sleep_end_event,
  input wire logic event_end_event,
  input wire logic cipher_event,
  input wire logic error_event,
  input wire logic gross_target_event,
  input wire logic fine_target_event,
  input wire logic radio_ctrl_event,
  output logic [31:0] reg_rdata,
  output logic [NSRC-1:0] irq_lines,
  output logic irq
);

  // ========================================================================
  // Elaboration check
  initial begin
    if (NSRC != `IRQ_NSRC) begin
      $error("radio_core_irq_status_ack serves exactly nine sources.");
    end
  end

  // ========================================================================
  // State
  typedef struct packed {
    logic [NSRC-1:0] enable;
    logic [31:0] rdata;
    logic [NSRC-1:0] lines;
    logic irq;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  irq_pkg::bus_req_t req;
  irq_pkg::src_vec_t set_vec;
  irq_pkg::src_vec_t clear_vec;
  irq_pkg::src_vec_t raw;
  irq_pkg::src_vec_t masked;
  logic [31:0] mux_rdata;

  // Decode of one register offset, used for every write target.
  function automatic logic hit(input logic [`IRQ_ADDR_W-1:0] a,
                               input logic [`IRQ_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr = reg_wr;
  assign req.rd = reg_rd;

  // ========================================================================
  // Source event vector, ordered by status bit position.
  always_comb begin
    set_vec = '0;
    set_vec[`IRQ_BIT_TICK] = tick_event;
    set_vec[`IRQ_BIT_RX] = receive_event;
    set_vec[`IRQ_BIT_SLEEP] = sleep_end_event;
    set_vec[`IRQ_BIT_EVENT] = event_end_event;
    set_vec[`IRQ_BIT_CIPHER] = cipher_event;
    set_vec[`IRQ_BIT_ERROR] = error_event;
    set_vec[`IRQ_BIT_GROSS] = gross_target_event;
    set_vec[`IRQ_BIT_FINE] = fine_target_event;
    set_vec[`IRQ_BIT_RADIO] = radio_ctrl_event;
  end

  // ========================================================================
  // Acknowledge decode. Each bit clears its own source only, so a 0 bit
  // leaves the matching flag alone and several may be cleared at once.
  always_comb begin
    clear_vec = '0;
    if (req.wr && hit(req.addr, `IRQ_OFS_ACK)) begin
      clear_vec[`IRQ_BIT_TICK] = req.wdata[`IRQ_BIT_TICK];
      clear_vec[`IRQ_BIT_RX] = req.wdata[`IRQ_BIT_RX];
      clear_vec[`IRQ_BIT_SLEEP] = req.wdata[`IRQ_BIT_SLEEP];
      clear_vec[`IRQ_BIT_EVENT] = req.wdata[`IRQ_BIT_EVENT];
      clear_vec[`IRQ_BIT_CIPHER] = req.wdata[`IRQ_BIT_CIPHER];
      clear_vec[`IRQ_BIT_ERROR] = req.wdata[`IRQ_BIT_ERROR];
      clear_vec[`IRQ_BIT_GROSS] = req.wdata[`IRQ_BIT_GROSS];
      clear_vec[`IRQ_BIT_FINE] = req.wdata[`IRQ_BIT_FINE];
      clear_vec[`IRQ_BIT_RADIO] = req.wdata[`IRQ_BIT_RADIO];
    end
  end

  // ========================================================================
  // Sticky raw flags; they reset to zero and software cannot write them.
  // flags reset zero
  irq_flag_bank #(
    .NSRC(NSRC)
  ) u_flags (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .set_pulse(set_vec),
    .clear_mask(clear_vec),
    .flags(raw)
  );

  assign masked = raw & s_q.enable;

  irq_read_mux u_rmux (
    .addr(req.addr),
    .enable(s_q.enable),
    .raw(raw),
    .level_style(`IRQ_LEVEL_STYLE_RST),
    .rdata(mux_rdata)
  );

  // ========================================================================
  // Next state: enable register, read data and interrupt outputs.
  always_comb begin
    s_d = s_q;
    if (req.wr && hit(req.addr, `IRQ_OFS_ENABLE)) begin
      s_d.enable = req.wdata[NSRC-1:0];
    end
    // Read data stand only in the cycle after the strobe.
    s_d.rdata = req.rd ? mux_rdata : 32'h00000000;
    s_d.lines = masked;
    s_d.irq = |masked;
  end

  // The outputs lag the flags by one cycle so every port is a flip-flop.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_q.enable <= `IRQ_ENABLE_RST;
      s_q.rdata <= 32'h00000000;
      s_q.lines <= `IRQ_FLAGS_RST;
      s_q.irq <= 1'h0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign irq_lines = s_q.lines;
  assign irq = s_q.irq;

endmodule : radio_core_irq_status_ack

// >>> radio_core_irq_status_ack_assertions.sv
// Concurrent checks of the interrupt status and acknowledge block.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`include "irq_cfg.svh"
module irq_status_checker #(
  parameter int NSRC = `IRQ_NSRC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [`IRQ_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic tick_event,
  input wire logic receive_event,
  input wire logic sleep_end_event,
  input wire logic event_end_event,
  input wire logic cipher_event,
  input wire logic error_event,
  input wire logic gross_target_event,
  input wire logic fine_target_event,
  input wire logic radio_ctrl_event,
  input wire logic [31:0] reg_rdata,
  input wire logic [NSRC-1:0] irq_lines,
  input wire logic irq
);
  // ==========================================================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // A set beside an ack wins, so clears are judged without events.
  logic any_ev;
  assign any_ev = tick_event | receive_event | sleep_end_event |
    event_end_event | cipher_event | error_event | gross_target_event |
    fine_target_event | radio_ctrl_event;
  sequence s_ack; reg_wr && reg_addr == `IRQ_OFS_ACK; endsequence
  sequence s_rd(a); reg_rd && reg_addr == a; endsequence
  property p_clear; s_ack ##0 !any_ev |=> ##1
    (irq_lines & $past(reg_wdata[NSRC-1:0], 2)) == '0; endproperty
  property p_keep; s_ack |=> ##1 ($past(irq_lines) &
    ~(irq_lines | $past(reg_wdata[NSRC-1:0], 2))) == '0; endproperty
  property p_hold; $past(resetn) && !$past(reg_wr, 2) |->
    ($past(irq_lines) & ~irq_lines) == '0; endproperty
  property p_or; irq == |irq_lines; endproperty
  property p_masked; s_rd(`IRQ_OFS_MASKED) |=>
    reg_rdata == 32'(irq_lines); endproperty
  property p_raw; s_rd(`IRQ_OFS_RAW) |=> reg_rdata[31:NSRC] == '0 &&
    (irq_lines & ~reg_rdata[NSRC-1:0]) == '0; endproperty
  property p_ackrd; s_rd(`IRQ_OFS_ACK) |=> reg_rdata == '0; endproperty
  property p_idle; !reg_rd |=> reg_rdata == '0; endproperty
  a_clear: assert property (p_clear)
    else $error("acknowledged flag stays set");
  a_keep: assert property (p_keep)
    else $error("zero ack bit cleared a flag");
  a_hold: assert property (p_hold)
    else $error("pending line dropped without ack");
  a_or: assert property (p_or)
    else $error("irq differs from its lines");
  a_masked: assert property (p_masked)
    else $error("masked view differs from lines");
  a_raw: assert property (p_raw)
    else $error("raw view lacks a pending flag");
  a_ackrd: assert property (p_ackrd)
    else $error("ack register read nonzero");
  a_idle: assert property (p_idle)
    else $error("read data outside read cycle");
endmodule : irq_status_checker
bind radio_core_irq_status_ack irq_status_checker #(.NSRC(NSRC))
  irq_status_checker_inst (.sys_clk, .resetn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .tick_event, .receive_event, .sleep_end_event,
  .event_end_event, .cipher_event, .error_event, .gross_target_event,
  .fine_target_event, .radio_ctrl_event, .reg_rdata, .irq_lines, .irq);

// >>> radio_core_irq_status_ack_tb_top.sv
// Self-checking bench of the interrupt status and acknowledge block.
// Assumes the design and checker files are compiled before it.
`timescale 1ns/1ps
`include "irq_cfg.svh"
module radio_core_irq_status_ack_tb_top;
  // ==========================================================
  // Stimulus and checks
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [8:0] ev = 9'h0;
  logic [8:0] irq_lines;
  logic irq;
  int error_cnt = 0;
  int check_count = 0;
  // Masked result of each single event under the reset enables.
  logic [8:0] exp_m [9] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010,
    9'h000, 9'h000, 9'h000, 9'h000};
  radio_core_irq_status_ack radio_core_irq_status_ack_inst (.sys_clk,
    .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tick_event(ev[0]), .receive_event(ev[1]), .sleep_end_event(ev[2]),
    .event_end_event(ev[3]), .cipher_event(ev[4]), .error_event(ev[5]),
    .gross_target_event(ev[6]), .fine_target_event(ev[7]),
    .radio_ctrl_event(ev[8]), .irq_lines, .irq);
  always #25 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [31:0] a, e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask : rd
  task automatic fire(input logic [8:0] v);
    @(posedge sys_clk);
    ev <= v;
    @(posedge sys_clk);
    ev <= 9'h0;
  endtask : fire
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  // The whole run is some 150 cycles; the watchdog allows far more.
  initial begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    results();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'h1;
    rd(`IRQ_OFS_ENABLE, 32'h1f); // enable reset
    rd(`IRQ_OFS_MASKED, 32'h0); // masked reset
    rd(`IRQ_OFS_RAW, 32'h0); // raw reset
    rd(`IRQ_OFS_ACK, 32'h0); // ack reads zero
    rd(32'h40000030, 32'h0);
    rd(`IRQ_OFS_CONFIG, 32'h10); // level style bit
    $display("reset test done");
    for (int i = 0; i < 9; i++) begin
      fire(9'h001 << i);
      rd(`IRQ_OFS_RAW, 32'h1 << i); // raw position
      chk("irq", irq, |exp_m[i]); // level output
      rd(`IRQ_OFS_MASKED, {23'h0, exp_m[i]}); // masked view
      wr(`IRQ_OFS_ACK, 32'h1 << i); // ack
      rd(`IRQ_OFS_RAW, 32'h0); // cleared
    end
    $display("row test done");
    wr(`IRQ_OFS_ENABLE, 32'hffffffff);
    rd(`IRQ_OFS_ENABLE, 32'h1ff); // upper bits dropped
    fire(9'h1ff);
    wr(`IRQ_OFS_ACK, 32'h0); // zero ack
    wr(`IRQ_OFS_RAW, 32'h0); // read-only write
    rd(`IRQ_OFS_MASKED, 32'h1ff); // all still set
    chk("irq_lines", irq_lines, 32'h1ff); // lines held
    wr(`IRQ_OFS_ACK, 32'h0aa); // partial ack
    rd(`IRQ_OFS_RAW, 32'h155); // others kept
    wr(`IRQ_OFS_ENABLE, 32'h1fe);
    wr(`IRQ_OFS_ACK, 32'h155);
    fire(9'h001);
    rd(`IRQ_OFS_MASKED, 32'h0); // tick masked off
    chk("irq", irq, 32'h0); // no output
    rd(`IRQ_OFS_RAW, 32'h1); // raw still set
    // An error event in the very cycle of its own ack must not be lost.
    @(posedge sys_clk);
    ev <= 9'h020;
    reg_addr <= `IRQ_OFS_ACK;
    reg_wdata <= 32'h20;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    ev <= 9'h0;
    reg_wr <= 1'h0;
    rd(`IRQ_OFS_RAW, 32'h21); // set beats clear
    $display("awkward test done");
    @(posedge sys_clk);
    resetn <= 1'h0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'h1;
    rd(`IRQ_OFS_ENABLE, 32'h1f); // enable restored
    rd(`IRQ_OFS_RAW, 32'h0); // flags cleared
    $display("second reset test done");
    results();
  end
endmodule : radio_core_irq_status_ack_tb_top
